// ### buffer_alternation.sv
/*
  buffer alternation and enable/disable handshake with APB registers.
  assumes the message processor runs on SYS_CLK_IN and gives start/end pulses.
*/
// Design decisions made here: the register offsets and the APB register port.
module buffer_alternation
  import alt_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic MSG_START_IN,
  input wire logic MSG_MODE_IN,
  input wire logic MSG_TX_IN,
  input wire logic [4:0] MSG_SA_IN,
  input wire logic MSG_END_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic SEL_VALID_OUT,
  output logic BUF_SEL_OUT,
  output logic BUF_READ_OUT
);
  // ****************************************
  // declarations
  // ****************************************
  logic [15:0] ctrl;
  logic ack;
  logic [6:0] desc_idx;
  logic [8:0] div_cnt;
  logic copy_due;
  logic copy_win;
  logic [2:0] wb_cnt;
  logic snap_en;
  logic snap_run;
  logic snap_circ;
  logic copy_fire;
  logic wb_fire;
  logic alt_now;
  msg_state_t m_state;
  logic [6:0] msg_idx;
  logic msg_tx;
  logic mem_re;
  logic mem_we;
  logic [DESC_AW-1:0] mem_addr;
  logic [DESC_DW-1:0] mem_wdata;
  logic [DESC_DW-1:0] mem_rdata;
  logic apb_go;
  logic apb_rd_wait;
  logic mem_free;
  logic apb_mem;
  logic wr_ctrl;
  logic [15:0] ctrl_view;

  function automatic logic is_circ(input logic [15:0] c);
    is_circ = c[CIRC_BIT];
  endfunction : is_circ

  assign apb_go = PSEL_IN && PENABLE_IN && !PREADY_OUT;
  assign wr_ctrl = apb_go && PWRITE_IN && (PADDR_IN == CTRL_OFS);
  assign alt_now = ack && ctrl[RUN_BIT] && !is_circ(ctrl);
  assign copy_fire = copy_due && !copy_win && (m_state == M_IDLE) && !MSG_START_IN;
  assign wb_fire = copy_win && (wb_cnt == WB_LAST);
  assign mem_free = !((m_state == M_IDLE) && MSG_START_IN) && (m_state != M_RD);
  assign apb_mem = apb_go && (PADDR_IN == DDAT_OFS) && !apb_rd_wait && mem_free;
  assign ctrl_view = {ctrl[15:10], ack, ctrl[8:0]};

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ctrl <= CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= PWDATA_IN[15:0] & CTRL_WMASK;
      end
      if (wb_fire) begin
        ctrl[ALT_EN_BIT] <= snap_en;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      desc_idx <= DIDX_RST;
    end else if (apb_go && PWRITE_IN && (PADDR_IN == DIDX_OFS)) begin
      desc_idx <= PWDATA_IN[6:0];
    end
  end

  // ****************************************
  // copy point divider
  // ****************************************
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      div_cnt <= 9'h000;
      copy_due <= 1'b0;
    end else begin
      if (div_cnt == COPY_LAST) begin
        div_cnt <= 9'h000;
      end else begin
        div_cnt <= div_cnt + 9'h001;
      end
      if (div_cnt == COPY_LAST) begin
        copy_due <= 1'b1;
      end else if (copy_fire) begin
        copy_due <= 1'b0;
      end
    end
  end

  // ****************************************
  // snapshot and write back
  // ****************************************
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      copy_win <= 1'b0;
      wb_cnt <= 3'h0;
      snap_en <= 1'b0;
      snap_run <= 1'b0;
      snap_circ <= 1'b0;
    end else if (copy_fire) begin
      copy_win <= 1'b1;
      wb_cnt <= 3'h0;
      snap_en <= ctrl[ALT_EN_BIT];
      snap_run <= ctrl[RUN_BIT];
      snap_circ <= is_circ(ctrl);
    end else if (wb_fire) begin
      copy_win <= 1'b0;
    end else if (copy_win) begin
      wb_cnt <= wb_cnt + 3'h1;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ack <= 1'b0;
    end else if (wb_fire) begin
      ack <= snap_en && snap_run && !snap_circ;
    end
  end

  // ****************************************
  // message sequencing
  // ****************************************
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      m_state <= M_IDLE;
      msg_idx <= 7'h00;
      msg_tx <= 1'b0;
    end else begin
      unique case (m_state)
        M_IDLE: begin
          if (MSG_START_IN) begin
            msg_idx <= {MSG_MODE_IN, MSG_TX_IN, MSG_SA_IN};
            msg_tx <= MSG_TX_IN;
            m_state <= M_RD;
          end
        end
        M_RD: begin
          m_state <= M_BUSY;
        end
        M_BUSY: begin
          if (MSG_END_IN) begin
            m_state <= M_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SEL_VALID_OUT <= 1'b0;
      BUF_SEL_OUT <= 1'b0;
      BUF_READ_OUT <= 1'b0;
    end else begin
      SEL_VALID_OUT <= (m_state == M_RD);
      if (m_state == M_RD) begin
        BUF_SEL_OUT <= mem_rdata[DESC_BUF_BIT];
        BUF_READ_OUT <= msg_tx;
      end
    end
  end

  // ****************************************
  // descriptor memory port
  // ****************************************
  always_comb begin
    mem_re = 1'b0;
    mem_we = 1'b0;
    mem_addr = desc_idx;
    mem_wdata = PWDATA_IN[15:0];
    if ((m_state == M_IDLE) && MSG_START_IN) begin
      mem_re = 1'b1;
      mem_addr = {MSG_MODE_IN, MSG_TX_IN, MSG_SA_IN};
    end else if (m_state == M_RD) begin
      mem_addr = msg_idx;
      mem_we = alt_now;
      mem_wdata = mem_rdata ^ BUF_FLIP_MASK;
    end else if (apb_mem) begin
      mem_we = PWRITE_IN;
      mem_re = !PWRITE_IN;
    end
  end

  desc_mem u_desc_mem (
    .clk_in(SYS_CLK_IN),
    .rst_b_in(RST_B_IN),
    .re_in(mem_re),
    .we_in(mem_we),
    .addr_in(mem_addr),
    .wdata_in(mem_wdata),
    .rdata_out(mem_rdata)
  );

  // ****************************************
  // apb slave
  // ****************************************
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= 32'h00000000;
      apb_rd_wait <= 1'b0;
    end else begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      if (apb_rd_wait) begin
        apb_rd_wait <= 1'b0;
        PREADY_OUT <= 1'b1;
        PRDATA_OUT <= {16'h0000, mem_rdata};
      end else if (apb_go) begin
        unique case (PADDR_IN)
          CTRL_OFS: begin
            PREADY_OUT <= 1'b1;
            PRDATA_OUT <= {16'h0000, ctrl_view};
          end
          STAT_OFS: begin
            PREADY_OUT <= 1'b1;
            PRDATA_OUT <= {29'h00000000, copy_win, alt_now, m_state != M_IDLE};
          end
          DIDX_OFS: begin
            PREADY_OUT <= 1'b1;
            PRDATA_OUT <= {25'h0000000, desc_idx};
          end
          DDAT_OFS: begin
            if (mem_free) begin
              PREADY_OUT <= PWRITE_IN;
              apb_rd_wait <= !PWRITE_IN;
            end
          end
          default: begin
            PREADY_OUT <= 1'b1;
            PSLVERR_OUT <= 1'b1;
            PRDATA_OUT <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [9:0] lag_cnt;
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      lag_cnt <= 10'h000;
    end else if ((m_state != M_IDLE) ||
                 (ack == (ctrl[ALT_EN_BIT] && ctrl[RUN_BIT] && !is_circ(ctrl)))) begin
      lag_cnt <= 10'h000;
    end else begin
      lag_cnt <= lag_cnt + 10'h001;
    end
  end

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  sequence s_copy_on;
    copy_fire && ctrl[RUN_BIT] && ctrl[ALT_EN_BIT] && !is_circ(ctrl);
  endsequence
  sequence s_ack_set;
    ##[1:8] ack;
  endsequence

  property p_flip;
    (m_state == M_RD && alt_now) |-> (mem_we && (mem_wdata[2] != mem_rdata[2]));
  endproperty
  a_flip: assert property (p_flip) else $error("active flag not inverted");

  property p_sel;
    (m_state == M_RD) |=> (SEL_VALID_OUT && (BUF_SEL_OUT == $past(mem_rdata[2])));
  endproperty
  a_sel: assert property (p_sel) else $error("buffer select wrong");

  property p_dir;
    SEL_VALID_OUT |-> (BUF_READ_OUT == msg_tx);
  endproperty
  a_dir: assert property (p_dir) else $error("buffer direction wrong");

  property p_frozen;
    (m_state == M_RD && !alt_now) |-> !mem_we;
  endproperty
  a_frozen: assert property (p_frozen) else $error("frozen entry rewritten");

  property p_circ;
    is_circ(ctrl) |-> !alt_now;
  endproperty
  a_circ: assert property (p_circ) else $error("alternation in circular mode");

  property p_ack_point;
    !$stable(ack) |-> $past(wb_fire);
  endproperty
  a_ack_point: assert property (p_ack_point) else $error("ack moved off copy point");

  property p_ack_value;
    wb_fire |=> (ack == $past(snap_en && snap_run && !snap_circ));
  endproperty
  a_ack_value: assert property (p_ack_value) else $error("ack not last state");

  property p_lost;
    wb_fire |=> (ctrl[ALT_EN_BIT] == $past(snap_en));
  endproperty
  a_lost: assert property (p_lost) else $error("late write not overwritten");

  property p_start;
    s_copy_on |-> s_ack_set;
  endproperty
  a_start: assert property (p_start) else $error("start did not set ack");

  property p_limit;
    lag_cnt < 10'(ACK_LIMIT_CYCLES);
  endproperty
  a_limit: assert property (p_limit) else $error("ack later than limit");
endmodule : buffer_alternation

// ### alt_pkg.sv
/*
  constants, offsets and types for the buffer alternation block.
  assumes a 20 MHz system clock and a 32-bit APB register bus.
*/
package alt_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] DIDX_OFS = 8'h08;
  localparam logic [7:0] DDAT_OFS = 8'h0C;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int RUN_BIT = 15;
  localparam int ACK_BIT = 9;
  localparam int CIRC_BIT = 8;
  localparam int ALT_EN_BIT = 2;
  localparam int DESC_BUF_BIT = 2;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hFDFF;
  localparam logic [15:0] BUF_FLIP_MASK = 16'h0004;
  localparam logic [6:0] DIDX_RST = 7'h00;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 20;
  localparam int COPY_PERIOD_US = 16;
  localparam int COPY_CYCLES = COPY_PERIOD_US * CLK_MHZ;
  localparam int ACK_LIMIT_US = 32;
  localparam int ACK_LIMIT_CYCLES = ACK_LIMIT_US * CLK_MHZ;
  localparam int WB_DELAY_CYCLES = 4;
  localparam logic [8:0] COPY_LAST = 9'(COPY_CYCLES - 1);
  localparam logic [2:0] WB_LAST = 3'(WB_DELAY_CYCLES - 1);
  // ****************************************
  // sizes and types
  // ****************************************
  localparam int DESC_AW = 7;
  localparam int DESC_DW = 16;
  typedef enum {M_IDLE, M_RD, M_BUSY} msg_state_t;
endpackage : alt_pkg

// ### desc_mem.sv
/*
  descriptor control word memory, one word per subaddress or mode code and direction.
  assumes one user per cycle; read data registered, held between reads.
*/
module desc_mem
  import alt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic re_in,
  input wire logic we_in,
  input wire logic [DESC_AW-1:0] addr_in,
  input wire logic [DESC_DW-1:0] wdata_in,
  output logic [DESC_DW-1:0] rdata_out
);
  // ****************************************
  // storage
  // ****************************************
  logic [DESC_DW-1:0] mem [0:(1<<DESC_AW)-1];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= 16'h0000;
    end else if (re_in) begin
      rdata_out <= mem[addr_in];
    end
  end
endmodule : desc_mem

// ### msg_proc_model.sv
/*
  message processor model: start pulse, wait for buffer select, end pulse.
  assumes the design's clock; command fields are only valid in the start cycle.
*/
module msg_proc_model (
  input wire logic clk_in,
  input wire logic sel_valid_in,
  output logic start_out,
  output logic mode_out,
  output logic tx_out,
  output logic [4:0] sa_out,
  output logic end_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    start_out = 1'b0;
    end_out = 1'b0;
    mode_out = 1'b0;
    tx_out = 1'b0;
    sa_out = 5'h00;
  end
  // ****************************************
  // one message, prompt or slow
  // ****************************************
  task automatic send(input logic m, input logic t, input logic [4:0] s, input int hold,
                      output logic ok);
    ok = 1'b0;
    @(posedge clk_in);
    start_out <= 1'b1;
    mode_out <= m;
    tx_out <= t;
    sa_out <= s;
    @(posedge clk_in);
    start_out <= 1'b0;
    // fields stale after start
    mode_out <= ~m;
    tx_out <= ~t;
    sa_out <= ~s;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk_in);
      ok = (sel_valid_in === 1'b1);
    end
    repeat (hold) @(posedge clk_in);
    end_out <= 1'b1;
    @(posedge clk_in);
    end_out <= 1'b0;
  endtask : send
endmodule : msg_proc_model

// ### tb_buffer_alternation.sv
/*
  testbench for buffer alternation: apb tasks, message calls, compares.
  assumes alt_pkg offsets and the message processor model.
*/
module tb_buffer_alternation;
  import alt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sel_valid, buf_sel, buf_read;
  logic mstart, mmode, mtx, mend;
  logic [4:0] msa;
  logic [31:0] rd;
  logic er, ok;
  int fails = 0;
  int checks = 0;
  always #25 clk = ~clk;
  buffer_alternation u_dut (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .MSG_START_IN(mstart), .MSG_MODE_IN(mmode), .MSG_TX_IN(mtx), .MSG_SA_IN(msa),
    .MSG_END_IN(mend), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .SEL_VALID_OUT(sel_valid), .BUF_SEL_OUT(buf_sel), .BUF_READ_OUT(buf_read));
  msg_proc_model u_mp (.clk_in(clk), .sel_valid_in(sel_valid), .start_out(mstart),
    .mode_out(mmode), .tx_out(mtx), .sa_out(msa), .end_out(mend));
  // ****************************************
  // report and compare
  // ****************************************
  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // ****************************************
  // bus and message access
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic msg(input logic m, input logic t, input logic [4:0] s, input int hold,
                     input logic [1:0] e, input string n);
    u_mp.send(m, t, s, hold, ok);
    chk("sel_valid", 32'h1, {31'h0, ok});
    chk(n, {30'h0, e}, {30'h0, buf_sel, buf_read});
  endtask : msg
  task automatic ack_wait(input logic [15:0] req, input logic e);
    int tr;
    int k;
    for (tr = 0; tr < 3; tr++) begin
      apb(1'b1, CTRL_OFS, {16'h0, req});
      for (k = 0; k < 170; k++) begin
        apb(1'b0, CTRL_OFS, 32'h0);
        if (rd[ACK_BIT] === e) break;
      end
      if (rd[ACK_BIT] === e) break;
    end
    chk("ack", {31'h0, e}, {31'h0, rd[ACK_BIT]});
    chk("ack_tries", 32'h1, {31'h0, tr < 2});
  endtask : ack_wait
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl_rst", 32'h0, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], er});
    apb(1'b1, DIDX_OFS, 32'h03);
    apb(1'b1, DDAT_OFS, 32'h0);
    apb(1'b1, DIDX_OFS, 32'h23);
    apb(1'b1, DDAT_OFS, 32'h4);
    apb(1'b1, DIDX_OFS, 32'h43);
    apb(1'b1, DDAT_OFS, 32'h0);
    $display("test reset done");
    ack_wait(16'h8004, 1'b1);
    msg(1'b0, 1'b0, 5'h03, 0, 2'b00, "rx1");
    msg(1'b0, 1'b0, 5'h03, 3, 2'b10, "rx2");
    msg(1'b0, 1'b1, 5'h03, 0, 2'b11, "tx1");
    msg(1'b1, 1'b0, 5'h03, 0, 2'b00, "mc1");
    apb(1'b0, DDAT_OFS, 32'h0);
    chk("desc_mc", 32'h4, rd);
    apb(1'b1, DIDX_OFS, 32'h23);
    apb(1'b0, DDAT_OFS, 32'h0);
    chk("desc_tx", 32'h0, rd);
    $display("test alternate done");
    ack_wait(16'h8000, 1'b0);
    msg(1'b0, 1'b0, 5'h03, 0, 2'b00, "frz1");
    msg(1'b0, 1'b0, 5'h03, 2, 2'b00, "frz2");
    apb(1'b1, CTRL_OFS, 32'h8200);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ack_ro", 32'h8000, rd);
    $display("test freeze done");
    ack_wait(16'h8004, 1'b1);
    msg(1'b0, 1'b0, 5'h03, 0, 2'b00, "res1");
    msg(1'b0, 1'b0, 5'h03, 0, 2'b10, "res2");
    apb(1'b0, STAT_OFS, 32'h0);
    chk("stat", 32'h2, rd & 32'hFFFFFFFB);
    ack_wait(16'h8104, 1'b0);
    msg(1'b0, 1'b0, 5'h03, 0, 2'b00, "circ1");
    msg(1'b0, 1'b0, 5'h03, 0, 2'b00, "circ2");
    $display("test resume done");
    ack_wait(16'h8004, 1'b1);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl_rerst", 32'h0, rd);
    msg(1'b0, 1'b0, 5'h03, 0, 2'b00, "rst1");
    msg(1'b0, 1'b0, 5'h03, 0, 2'b00, "rst2");
    $display("test mid-run reset done");
    final_report();
  end
endmodule : tb_buffer_alternation
